// file: src/alpc_pkg.sv
// Package for the converter low-power and setup control block.
// Assumes a single 250 MHz bus clock and an AXI4-Lite register bus with 32-bit data.
package alpc_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONV_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_TRIG_CMP_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CHAN_STATUS_CTRL = 8'h08;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h10;
  localparam logic [7:0] ADDR_CMP_VALUE_HIGH = 8'h14;
  localparam logic [7:0] ADDR_CMP_VALUE_LOW = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CFG_LOW_POWER_BIT = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LONG_SAMPLE_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_SEL_LSB = 0;
  localparam int TCC_ACTIVE_BIT = 7;
  localparam int TCC_TRIG_SEL_BIT = 6;
  localparam int TCC_CMP_EN_BIT = 5;
  localparam int TCC_CMP_GT_BIT = 4;
  localparam int CSC_FLAG_BIT = 7;
  localparam int CSC_IRQ_EN_BIT = 6;
  localparam int CSC_CONT_BIT = 5;
  localparam int CSC_CHAN_LSB = 0;

  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_10BIT = 2'h2;
  localparam logic [1:0] CLK_SEL_BUS = 2'h0;
  localparam logic [1:0] CLK_SEL_ASYNC = 2'h3;
  localparam logic [4:0] CHAN_DISABLED = 5'h1f;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [4:0] CHAN_RESET = 5'h1f;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Settings handed to the analog converter with each start
  typedef struct packed {
    logic [4:0] channel_select;
    logic [1:0] resolution;
    logic long_sample_select;
    logic low_power_select;
    logic [1:0] clock_divider;
    logic [1:0] input_clock_select;
  } alpc_conv_cfg_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } alpc_state_t;

endpackage : alpc_pkg

// file: src/alpc_top.sv
// Converter control: AXI4-Lite registers, trigger handling, stop-mode behaviour.
// Assumes stop, trigger and converter signals come from logic on core_clk_in.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps

module alpc_top (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic shallow_stop_in,
  input wire logic deep_stop_in,
  input wire logic hw_trigger_in,
  input wire logic conv_done_in,
  input wire logic [9:0] conv_data_in,
  output logic conv_start_out,
  output logic conv_abort_out,
  output alpc_pkg::alpc_conv_cfg_t conv_cfg_out,
  output logic conv_active_out,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Keeps only the bits that the selected resolution produces
  function automatic logic [9:0] res_mask(input logic [1:0] mode, input logic [9:0] val);
    res_mask = (mode == alpc_pkg::MODE_10BIT) ? val : {2'h0, val[7:0]};
  endfunction : res_mask

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] cfg_q;
  logic trig_sel_q;
  logic cmp_en_q;
  logic cmp_gt_q;
  logic irq_en_q;
  logic cont_q;
  logic [4:0] chan_q;
  logic flag_q;
  logic block_q;
  logic [9:0] result_q;
  logic [9:0] cmp_val_q;
  alpc_pkg::alpc_state_t state_q;
  logic stop_q;
  logic hw_trig_q;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  logic wr_fire;
  logic rd_fire;
  logic wr_cfg;
  logic wr_tcc;
  logic wr_csc;
  logic wr_cvh;
  logic wr_cvl;
  logic rd_high;
  logic rd_low;
  logic async_sel;
  logic halted;
  logic stop_entry_abort;
  logic mode_abort;
  logic busy;
  logic done;
  logic [10:0] diff;
  logic cond_ok;
  logic xfer;
  logic restart;
  logic sw_start;
  logic hw_start;
  logic any_abort;
  logic [7:0] rd_byte;
  logic rd_mapped;

  // Write happens once both address and data are held and no response pends
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid_out;
  assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
  // Only the low byte lane carries register data
  assign wr_cfg = wr_fire && wstrb_q[0] && aw_addr_q == alpc_pkg::ADDR_CONV_CONFIG;
  assign wr_tcc = wr_fire && wstrb_q[0] && aw_addr_q == alpc_pkg::ADDR_TRIG_CMP_CTRL;
  assign wr_csc = wr_fire && wstrb_q[0] && aw_addr_q == alpc_pkg::ADDR_CHAN_STATUS_CTRL;
  assign wr_cvh = wr_fire && wstrb_q[0] && aw_addr_q == alpc_pkg::ADDR_CMP_VALUE_HIGH;
  assign wr_cvl = wr_fire && wstrb_q[0] && aw_addr_q == alpc_pkg::ADDR_CMP_VALUE_LOW;
  assign rd_high = rd_fire && s_axi_araddr_in == alpc_pkg::ADDR_RESULT_HIGH;
  assign rd_low = rd_fire && s_axi_araddr_in == alpc_pkg::ADDR_RESULT_LOW;

  // Stop behaviour hinges on whether the converter owns its clock
  assign async_sel = cfg_q[1:0] == alpc_pkg::CLK_SEL_ASYNC;
  assign halted = shallow_stop_in && !async_sel;
  assign stop_entry_abort = shallow_stop_in && !stop_q && !async_sel;
  // Any mode change invalidates the running conversion
  assign mode_abort = wr_cfg || wr_tcc || wr_cvh || wr_cvl || wr_csc;
  assign any_abort = mode_abort || stop_entry_abort || deep_stop_in;
  assign busy = state_q == alpc_pkg::ST_BUSY;
  assign done = conv_done_in && busy && !any_abort;

  // Compare: result plus two's complement of the compare value
  assign diff = {1'b0, res_mask(cfg_q[3:2], conv_data_in)} - {1'b0, cmp_val_q};
  assign cond_ok = !cmp_en_q || (cmp_gt_q ? !diff[10] : diff[10]);
  assign xfer = done && !block_q && cond_ok;
  // Blocked results re-run unless a single compare conversion failed
  assign restart = done && (cont_q || (block_q && cond_ok)) && !halted;

  // Held write data, not the live bus, since the master may already have moved on
  assign sw_start = wr_csc && !trig_sel_q && wdata_q[4:0] != alpc_pkg::CHAN_DISABLED;
  // Hardware trigger is an edge from on-chip logic, so it is used unsynchronised
  assign hw_start = hw_trigger_in && !hw_trig_q && trig_sel_q && !busy && !halted &&
    chan_q != alpc_pkg::CHAN_DISABLED && !any_abort && !deep_stop_in;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Deep stop forces every register back to reset value
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_q <= alpc_pkg::CFG_RESET;
      trig_sel_q <= 1'b0;
      cmp_en_q <= 1'b0;
      cmp_gt_q <= 1'b0;
      irq_en_q <= 1'b0;
      cont_q <= 1'b0;
      chan_q <= alpc_pkg::CHAN_RESET;
      cmp_val_q <= alpc_pkg::RESULT_RESET;
    end else if (deep_stop_in) begin
      cfg_q <= alpc_pkg::CFG_RESET;
      trig_sel_q <= 1'b0;
      cmp_en_q <= 1'b0;
      cmp_gt_q <= 1'b0;
      irq_en_q <= 1'b0;
      cont_q <= 1'b0;
      chan_q <= alpc_pkg::CHAN_RESET;
      cmp_val_q <= alpc_pkg::RESULT_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_q <= wdata_q[7:0];
      end
      if (wr_tcc) begin
        trig_sel_q <= wdata_q[alpc_pkg::TCC_TRIG_SEL_BIT];
        cmp_en_q <= wdata_q[alpc_pkg::TCC_CMP_EN_BIT];
        cmp_gt_q <= wdata_q[alpc_pkg::TCC_CMP_GT_BIT];
      end
      if (wr_csc) begin
        irq_en_q <= wdata_q[alpc_pkg::CSC_IRQ_EN_BIT];
        cont_q <= wdata_q[alpc_pkg::CSC_CONT_BIT];
        chan_q <= wdata_q[4:0];
      end
      if (wr_cvh) begin
        cmp_val_q[9:8] <= wdata_q[1:0];
      end
      if (wr_cvl) begin
        cmp_val_q[7:0] <= wdata_q[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequencing
  // ---------------------------------------------------------------
  // Start and abort are pulses to the analog side; settings travel with them
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= alpc_pkg::ST_IDLE;
      conv_start_out <= 1'b0;
      conv_abort_out <= 1'b0;
      conv_cfg_out <= '0;
      stop_q <= 1'b0;
      hw_trig_q <= 1'b0;
    end else begin
      stop_q <= shallow_stop_in;
      hw_trig_q <= hw_trigger_in;
      conv_abort_out <= busy && any_abort;
      conv_start_out <= 1'b0;
      conv_cfg_out <= '{channel_select: chan_q, resolution: cfg_q[3:2],
        long_sample_select: cfg_q[4], low_power_select: cfg_q[7],
        clock_divider: cfg_q[6:5], input_clock_select: cfg_q[1:0]};
      if (sw_start && !deep_stop_in && !halted) begin
        state_q <= alpc_pkg::ST_BUSY;
        conv_start_out <= 1'b1;
        conv_cfg_out.channel_select <= wdata_q[4:0];
      end else if (any_abort) begin
        state_q <= alpc_pkg::ST_IDLE;
      end else if (hw_start || restart) begin
        state_q <= alpc_pkg::ST_BUSY;
        conv_start_out <= 1'b1;
      end else if (done) begin
        state_q <= alpc_pkg::ST_IDLE;
      end
    end
  end

  // Active indication follows the sequencer
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_active_out <= 1'b0;
    end else begin
      conv_active_out <= busy;
    end
  end

  // ---------------------------------------------------------------
  // Result, flag, blocking and interrupt
  // ---------------------------------------------------------------
  // Flag set wins over a same-cycle clear so no completion is lost
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_q <= alpc_pkg::RESULT_RESET;
      flag_q <= 1'b0;
      block_q <= 1'b0;
      irq_out <= 1'b0;
    end else if (deep_stop_in) begin
      result_q <= alpc_pkg::RESULT_RESET;
      flag_q <= 1'b0;
      block_q <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      if (xfer) begin
        result_q <= cmp_en_q ? diff[9:0] : res_mask(cfg_q[3:2], conv_data_in);
      end
      if (xfer) begin
        flag_q <= 1'b1;
      end else if (wr_csc || rd_low) begin
        flag_q <= 1'b0;
      end
      // Blocking protects a half-read 10-bit pair
      if (rd_low) begin
        block_q <= 1'b0;
      end else if (rd_high && cfg_q[3:2] == alpc_pkg::MODE_10BIT) begin
        block_q <= 1'b1;
      end
      irq_out <= flag_q && irq_en_q;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  always_comb begin
    rd_mapped = 1'b1;
    case (s_axi_araddr_in)
      alpc_pkg::ADDR_CONV_CONFIG: rd_byte = cfg_q;
      alpc_pkg::ADDR_TRIG_CMP_CTRL: rd_byte = {busy, trig_sel_q, cmp_en_q, cmp_gt_q, 4'h0};
      alpc_pkg::ADDR_CHAN_STATUS_CTRL: rd_byte = {flag_q, irq_en_q, cont_q, chan_q};
      alpc_pkg::ADDR_RESULT_HIGH: rd_byte = {6'h00, result_q[9:8]};
      alpc_pkg::ADDR_RESULT_LOW: rd_byte = result_q[7:0];
      alpc_pkg::ADDR_CMP_VALUE_HIGH: rd_byte = {6'h00, cmp_val_q[9:8]};
      alpc_pkg::ADDR_CMP_VALUE_LOW: rd_byte = cmp_val_q[7:0];
      default: begin
        rd_byte = 8'h00;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // Write channels taken independently, one write outstanding
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= alpc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= (aw_addr_q <= alpc_pkg::ADDR_CMP_VALUE_LOW && aw_addr_q[1:0] == 2'h0)
          ? alpc_pkg::RESP_OKAY : alpc_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // Read answered one cycle after the address is taken
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= alpc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {24'h000000, rd_byte};
      s_axi_rresp_out <= rd_mapped ? alpc_pkg::RESP_OKAY : alpc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  stop_abort_a: assert property (stop_entry_abort && busy && !sw_start |=>
    !busy && conv_abort_out) else $error("busy after stop entry");
  result_keep_a: assert property (shallow_stop_in && !async_sel && !deep_stop_in |=>
    $stable(result_q)) else $error("result changed in stop");
  stay_idle_a: assert property (halted && !busy |=> !conv_start_out && !busy)
    else $error("start while halted");
  async_run_a: assert property (shallow_stop_in && async_sel && busy && !conv_done_in &&
    !any_abort |=> busy) else $error("async conversion dropped");
  cont_restart_a: assert property (done && cont_q && !halted && !sw_start |=>
    conv_start_out && busy) else $error("no continuous restart");
  flag_irq_a: assert property (xfer && irq_en_q && !deep_stop_in |=> flag_q ##1
    (irq_out || $past(deep_stop_in))) else $error("completion interrupt missing");
  deep_clear_a: assert property (deep_stop_in |=> cfg_q == alpc_pkg::CFG_RESET && !busy &&
    chan_q == alpc_pkg::CHAN_RESET && !flag_q) else $error("deep stop left state");
  block_drop_a: assert property (done && block_q && !rd_low && !deep_stop_in |=>
    $stable(result_q) && flag_q == $past(flag_q)) else $error("blocked result stored");
  csc_start_a: assert property (sw_start && !deep_stop_in && !halted |=>
    conv_start_out && conv_cfg_out.channel_select == $past(wdata_q[4:0]))
    else $error("channel write did not start");
  active_bit_a: assert property (busy |=> conv_active_out) else $error("active flag low");

endmodule : alpc_top

// file: tb/tb_top.sv
// Self-checking bench for the converter low-power and setup control block.
// Assumes the bench drives registers over AXI4-Lite and also plays the converter.
`timescale 1ns/100ps

module tb_top;
  // ---------------------------------------------------------------
  // Signals and clock
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic shallow_stop, deep_stop, hw_trigger, conv_done;
  logic [9:0] conv_data;
  logic conv_start, conv_abort, conv_active, irq;
  alpc_pkg::alpc_conv_cfg_t conv_cfg, last_cfg;
  int err_count = 0;
  int tests_run = 0;
  int starts = 0;
  int aborts = 0;
  int s0, a0;

  // 250 MHz bus clock
  always #2 clk = ~clk;

  alpc_top u_alpc_top (
    .core_clk_in(clk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .shallow_stop_in(shallow_stop), .deep_stop_in(deep_stop), .hw_trigger_in(hw_trigger),
    .conv_done_in(conv_done), .conv_data_in(conv_data), .conv_start_out(conv_start),
    .conv_abort_out(conv_abort), .conv_cfg_out(conv_cfg), .conv_active_out(conv_active),
    .irq_out(irq)
  );

  // Count one-cycle pulses so checks need not hit the exact cycle
  always @(posedge clk) begin
    if (conv_start === 1'b1) begin
      starts <= starts + 1;
      last_cfg <= conv_cfg;
    end
    if (conv_abort === 1'b1) aborts <= aborts + 1;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Write with both channels offered together, bready held until bvalid
  // Waits as long as the slave needs; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= {24'h000000, d}; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er, "write response");
  endtask : wr

  // Read and compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed, "read data");
    chk(rresp, er, "read response");
  endtask : rd

  // Converter reports a finished result, then flag and irq settle
  task automatic done(input logic [9:0] d);
    @(posedge clk);
    conv_done <= 1'b1; conv_data <= d;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : done

  task automatic trig();
    @(posedge clk);
    hw_trigger <= 1'b1;
    repeat (2) @(posedge clk);
    hw_trigger <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : trig

  task automatic test_done();
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    err_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    test_done();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'hf; wvalid = 1'b0;
    bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
    shallow_stop = 1'b0; deep_stop = 1'b0; hw_trigger = 1'b0;
    conv_done = 1'b0; conv_data = 10'h000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, unmapped place, reserved bits
    rd(8'h00, 32'h00, 2'h0);
    rd(8'h08, 32'h1f, 2'h0);
    rd(8'h0c, 32'h00, 2'h0);
    rd(8'h1c, 32'h00, alpc_pkg::RESP_SLVERR);
    wr(8'h1c, 8'h55, alpc_pkg::RESP_SLVERR);
    wr(8'h04, 8'h7c, 2'h0);
    rd(8'h04, 32'h70, 2'h0);
    $display("test registers done");
    // Software start, 10-bit, channel 1, irq enabled
    wr(8'h00, 8'h98, 2'h0);
    wr(8'h04, 8'h00, 2'h0);
    wr(8'h08, 8'h41, 2'h0);
    repeat (3) @(posedge clk);
    chk(starts, 1, "software start");
    chk(last_cfg, {5'h01, alpc_pkg::MODE_10BIT, 1'b1, 1'b1, 2'h0, alpc_pkg::CLK_SEL_BUS}, "cfg");
    rd(8'h04, 32'h80, 2'h0);
    done(10'h2a5);
    rd(8'h08, 32'hc1, 2'h0);
    chk(irq, 1'b1, "irq on complete");
    rd(8'h0c, 32'h02, 2'h0);
    rd(8'h10, 32'ha5, 2'h0);
    $display("test single conversion done");
    // Shallow stop on bus clock aborts, stays idle afterwards
    wr(8'h08, 8'h01, 2'h0);
    repeat (3) @(posedge clk);
    a0 = aborts;
    s0 = starts;
    shallow_stop <= 1'b1;
    repeat (4) @(posedge clk);
    chk(aborts, a0 + 1, "stop abort");
    chk(conv_active, 1'b0, "idle in stop");
    done(10'h3ff);
    shallow_stop <= 1'b0;
    repeat (6) @(posedge clk);
    chk(starts, s0, "no restart after stop");
    rd(8'h0c, 32'h02, 2'h0);
    rd(8'h10, 32'ha5, 2'h0);
    rd(8'h08, 32'h01, 2'h0);
    $display("test shallow stop bus clock done");
    // Async clock: conversions run on and start in shallow stop
    wr(8'h00, 8'h9b, 2'h0);
    wr(8'h04, 8'h40, 2'h0);
    wr(8'h08, 8'h41, 2'h0);
    repeat (3) @(posedge clk);
    s0 = starts;
    trig();
    chk(starts, s0 + 1, "hardware start");
    a0 = aborts;
    shallow_stop <= 1'b1;
    repeat (4) @(posedge clk);
    chk(aborts, a0, "no abort with async clock");
    chk(conv_active, 1'b1, "still active");
    done(10'h155);
    chk(irq, 1'b1, "wake irq");
    trig();
    chk(starts, s0 + 2, "trigger in stop");
    done(10'h0aa);
    shallow_stop <= 1'b0;
    rd(8'h08, 32'hc1, 2'h0);
    rd(8'h0c, 32'h00, 2'h0);
    rd(8'h10, 32'haa, 2'h0);
    $display("test shallow stop async clock done");
    // Blocking after a high read; then channel all ones only aborts
    wr(8'h04, 8'h00, 2'h0);
    wr(8'h00, 8'h98, 2'h0);
    wr(8'h08, 8'h01, 2'h0);
    repeat (3) @(posedge clk);
    s0 = starts;
    rd(8'h0c, 32'h00, 2'h0);
    done(10'h3ff);
    chk(starts, s0 + 1, "restart when blocked");
    rd(8'h08, 32'h01, 2'h0);
    rd(8'h10, 32'haa, 2'h0);
    a0 = aborts;
    s0 = starts;
    wr(8'h08, 8'h1f, 2'h0);
    repeat (3) @(posedge clk);
    chk(aborts, a0 + 1, "write aborts");
    chk(starts, s0, "all ones no start");
    $display("test blocking done");
    // Continuous conversions restart by themselves
    wr(8'h08, 8'h21, 2'h0);
    repeat (3) @(posedge clk);
    s0 = starts;
    done(10'h123);
    chk(starts, s0 + 1, "continuous restart");
    rd(8'h08, 32'ha1, 2'h0);
    rd(8'h0c, 32'h01, 2'h0);
    rd(8'h10, 32'h23, 2'h0);
    wr(8'h08, 8'h1f, 2'h0);
    $display("test continuous done");
    // Compare in 8-bit mode: a true result is stored as the difference, a false one dropped
    wr(8'h18, 8'h10, 2'h0);
    wr(8'h00, 8'h00, 2'h0);
    wr(8'h04, 8'h30, 2'h0);
    wr(8'h08, 8'h01, 2'h0);
    repeat (3) @(posedge clk);
    done(10'h325);
    rd(8'h08, 32'h81, 2'h0);
    rd(8'h10, 32'h15, 2'h0);
    wr(8'h08, 8'h01, 2'h0);
    repeat (3) @(posedge clk);
    done(10'h005);
    rd(8'h08, 32'h01, 2'h0);
    rd(8'h10, 32'h15, 2'h0);
    rd(8'h04, 32'h30, 2'h0);
    $display("test compare done");
    // Deep stop disables and resets everything
    wr(8'h00, 8'h9b, 2'h0);
    wr(8'h08, 8'h41, 2'h0);
    repeat (3) @(posedge clk);
    deep_stop <= 1'b1;
    repeat (3) @(posedge clk);
    deep_stop <= 1'b0;
    repeat (3) @(posedge clk);
    s0 = starts;
    chk(conv_active, 1'b0, "deep stop disables");
    rd(8'h00, 32'h00, 2'h0);
    rd(8'h04, 32'h00, 2'h0);
    rd(8'h08, 32'h1f, 2'h0);
    rd(8'h0c, 32'h00, 2'h0);
    rd(8'h10, 32'h00, 2'h0);
    chk(starts, s0, "no start after deep stop");
    $display("test deep stop done");
    test_done();
  end
endmodule : tb_top
